// *** logic/isc_pkg.sv ***
// constants, field layouts and carriers for the deep idle standby control
// assumes one 125 MHz clock and a simple strobe register port
// Operation
// - mode field 10 then stop bit 1 enters deep idle on that write
// - oscillator runs; cpu, pll, flash and peripheral clocks are cut in deep idle
// - execution halts and ram contents are held unchanged during deep idle
// - peripherals on subclock or external clock keep running in deep idle
// - an unmasked request already pending at entry ends deep idle at once
// - nmi, watchdog, external, peripheral interrupts or any reset end deep idle
// - release restores the pll state held before entry, then normal run
// - nmi or unmasked maskable request wakes regardless of its priority
// - lower priority request inside a handler wakes but is not acknowledged
// - higher priority or nmi request inside a handler wakes and is acknowledged
// - requests disabled by the three mask bits never end deep idle
// - after nmi wake and setup time execution always branches to the handler
// - maskable wake branches or continues when enabled, continues when disabled
// - reset during deep idle behaves as an ordinary reset
// - pll, cpu, dma, rom correction, timers stop; intc stops but can wake
// - interval timer runs on internal osc by eight or subclock, else stops
// - watch timer runs on divided main clock, always with subclock present
// - watchdog runs on internal oscillator, or subclock when present
// - a setup interval for pll and flash precedes resumed execution
// - interrupt wake counts the stabilise register interval to overflow
// - reset release waits the stabilise reset value, two to the power sixteen periods

package isc_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_POWER_SAVE_MODE = 4'h0;
   localparam logic [3:0] ADDR_STANDBY_CONTROL = 4'h4;
   localparam logic [3:0] ADDR_OSC_STABILIZE = 4'h8;
   localparam logic [3:0] ADDR_STATUS = 4'hC;

   // ----------------------------------------------------------------
   // field positions and values
   // ----------------------------------------------------------------
   localparam int SAVE_MODE_SEL_LO_BIT = 0;
   localparam int SAVE_MODE_SEL_HI_BIT = 1;
   localparam logic [1:0] MODE_DEEP_IDLE = 2'h2;
   localparam int STANDBY_ENTRY_BIT = 1;
   localparam int NONMASKABLE_SRC0_MASK_BIT = 2;
   localparam int NONMASKABLE_SRC1_MASK_BIT = 3;
   localparam int MASKABLE_IRQ_MASK_BIT = 4;
   localparam logic [1:0] POWER_SAVE_MODE_RESET = 2'h0;
   localparam logic [2:0] OSC_STABILIZE_RESET = 3'h6;
   localparam int OSC_SHIFT_BASE = 10;
   localparam int SETUP_CNT_W = 20;

   // ----------------------------------------------------------------
   // clock selection codes
   // ----------------------------------------------------------------
   localparam logic [1:0] ITMR_SEL_INT_OSC_DIV8 = 2'h1;
   localparam logic [1:0] ITMR_SEL_SUBCLOCK = 2'h2;
   localparam logic [1:0] WTMR_SEL_MAIN_DIV = 2'h0;
   localparam logic [1:0] WDOG_SEL_INT_OSC = 2'h0;
   localparam logic [1:0] WDOG_SEL_SUBCLOCK = 2'h1;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef enum {ST_RESET_SETUP, ST_RUN, ST_ENTRY, ST_IDLE, ST_SETUP} isc_state_type;

   typedef struct packed {
      logic cpu;
      logic pll;
      logic flash;
      logic periph;
      logic dma;
      logic rom_corr;
      logic gen_timer;
      logic intc;
      logic interval_timer;
      logic watch_timer;
      logic watchdog;
      logic ext_clk_periph;
   } isc_clk_en_type;

   typedef struct packed {
      logic [1:0] interval_timer;
      logic [1:0] watch_timer;
      logic [1:0] watchdog;
   } isc_clk_sel_type;

endpackage : isc_pkg

// *** logic/isc_standby_ctrl.sv ***
// deep idle standby controller: mode registers, clock gating, wake and setup timing
// assumes interrupt controller and cpu share ref_clk; nmi and external pins are async
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/100ps

module isc_standby_ctrl #(
   parameter int OSC_SHIFT_BASE = isc_pkg::OSC_SHIFT_BASE,
   parameter int EXT_IRQ_W = 8,
   parameter int PERIPH_IRQ_W = 8,
   parameter int PRIO_W = 3
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic nmi_pin,
   input wire logic watchdog_irq,
   input wire logic [EXT_IRQ_W-1:0] external_irq_pins,
   input wire logic [EXT_IRQ_W-1:0] external_irq_mask,
   input wire logic [PERIPH_IRQ_W-1:0] periph_irq,
   input wire logic [PERIPH_IRQ_W-1:0] periph_irq_mask,
   input wire logic [PERIPH_IRQ_W-1:0] periph_idle_capable,
   input wire logic [PRIO_W-1:0] request_prio,
   input wire logic [PRIO_W-1:0] service_prio,
   input wire logic in_service,
   input wire logic irq_enabled,
   input wire logic watchdog_reset,
   input wire logic clock_monitor_reset,
   input wire logic subclock_present,
   input wire logic pll_run_sw,
   input wire isc_pkg::isc_clk_sel_type clk_sel,
   output isc_pkg::isc_clk_en_type clk_en,
   output logic osc_run,
   output logic pll_run,
   output logic ram_hold,
   output logic cpu_halt,
   output logic sys_reset_req,
   output logic resume,
   output logic resume_branch,
   output logic irq_ack_allow
);
   import isc_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic nmi_meta;
      logic nmi_sync;
      logic [EXT_IRQ_W-1:0] ext_meta;
      logic [EXT_IRQ_W-1:0] ext_sync;

      logic [1:0] power_save_mode_reg;
      logic nonmaskable_src0_mask;
      logic nonmaskable_src1_mask;
      logic maskable_irq_mask;
      logic [2:0] osc_stabilize_select_reg;

      isc_state_type state;
      logic [SETUP_CNT_W-1:0] setup_cnt;
      logic pll_saved;
      logic wake_branch;
      logic wake_ack;

      logic [31:0] rdata;

      isc_clk_en_type clk_en;
      logic pll_run;
      logic ram_hold;
      logic cpu_halt;
      logic resume;
      logic resume_branch;
      logic irq_ack_allow;
      logic sys_reset_req;
   } isc_regs_type;

   isc_regs_type st_reg;
   isc_regs_type st_next;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [SETUP_CNT_W-1:0] setup_cycles(input logic [2:0] sel);
      int shift;

      shift = OSC_SHIFT_BASE + int'(sel);
      if (shift > SETUP_CNT_W - 1) begin
         shift = SETUP_CNT_W - 1;
      end
      // clipped so a large select cannot shift the one out of the counter
      setup_cycles = SETUP_CNT_W'(1) << shift;
   endfunction : setup_cycles

   function automatic isc_clk_en_type clocks_all_on();
      clocks_all_on = '1;
   endfunction : clocks_all_on

   // ----------------------------------------------------------------
   // wake decode
   // ----------------------------------------------------------------
   logic nmi_wake;
   logic mask_wake;
   logic any_wake;

   logic higher_prio;
   logic entry_write;
   logic reset_src;
   isc_clk_en_type idle_clk;

   always_comb begin
      // masked sources are invalid as wake events
      nmi_wake = (st_reg.nmi_sync & ~st_reg.nonmaskable_src0_mask)
         | (watchdog_irq & ~st_reg.nonmaskable_src1_mask);
      // peripherals that are halted cannot raise a request, only idle capable ones count
      mask_wake = ~st_reg.maskable_irq_mask
         & ((|(st_reg.ext_sync & ~external_irq_mask))
         | (|(periph_irq & ~periph_irq_mask & periph_idle_capable)));
      // priority is ignored for the wake itself
      any_wake = nmi_wake | mask_wake;

      // lower value is higher priority; outside a handler every request is taken
      higher_prio = ~in_service | (request_prio < service_prio);
      entry_write = reg_wr && (reg_addr == ADDR_STANDBY_CONTROL)
         && reg_wdata[STANDBY_ENTRY_BIT]
         && (st_reg.power_save_mode_reg == MODE_DEEP_IDLE);

      // these only request a reset; the system feeds it back on reset_n
      reset_src = watchdog_reset | clock_monitor_reset;
   end

   // ----------------------------------------------------------------
   // clock gating while idle
   // ----------------------------------------------------------------
   always_comb begin
      idle_clk = '0;
      // intc keeps its wake path alive but its core clock stops
      idle_clk.intc = 1'b0;
      idle_clk.ext_clk_periph = 1'b1;

      idle_clk.interval_timer = (clk_sel.interval_timer == ITMR_SEL_INT_OSC_DIV8)
         | (subclock_present & (clk_sel.interval_timer == ITMR_SEL_SUBCLOCK));
      idle_clk.watch_timer = subclock_present
         | (clk_sel.watch_timer == WTMR_SEL_MAIN_DIV);
      idle_clk.watchdog = (clk_sel.watchdog == WDOG_SEL_INT_OSC)
         | (subclock_present & (clk_sel.watchdog == WDOG_SEL_SUBCLOCK));
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      // two flops on the async pins before any wake logic reads them
      st_next.nmi_meta = nmi_pin;
      st_next.nmi_sync = st_reg.nmi_meta;
      st_next.ext_meta = external_irq_pins;
      st_next.ext_sync = st_reg.ext_meta;
      st_next.resume = 1'b0;
      st_next.irq_ack_allow = 1'b0;
      st_next.sys_reset_req = reset_src;


      // register writes
      if (reg_wr) begin
         case (reg_addr)
            ADDR_POWER_SAVE_MODE: begin
               st_next.power_save_mode_reg = {reg_wdata[SAVE_MODE_SEL_HI_BIT],
                  reg_wdata[SAVE_MODE_SEL_LO_BIT]};
            end
            ADDR_STANDBY_CONTROL: begin
               st_next.nonmaskable_src0_mask = reg_wdata[NONMASKABLE_SRC0_MASK_BIT];
               st_next.nonmaskable_src1_mask = reg_wdata[NONMASKABLE_SRC1_MASK_BIT];
               st_next.maskable_irq_mask = reg_wdata[MASKABLE_IRQ_MASK_BIT];
            end
            ADDR_OSC_STABILIZE: begin
               st_next.osc_stabilize_select_reg = reg_wdata[2:0];
            end
            default: begin
            end
         endcase
      end


      // register reads, data stand in the next cycle only
      st_next.rdata = '0;
      if (reg_rd) begin
         case (reg_addr)
            ADDR_POWER_SAVE_MODE: begin
               st_next.rdata[1:0] = st_reg.power_save_mode_reg;
            end
            ADDR_STANDBY_CONTROL: begin
               st_next.rdata[NONMASKABLE_SRC0_MASK_BIT] = st_reg.nonmaskable_src0_mask;
               st_next.rdata[NONMASKABLE_SRC1_MASK_BIT] = st_reg.nonmaskable_src1_mask;
               st_next.rdata[MASKABLE_IRQ_MASK_BIT] = st_reg.maskable_irq_mask;
            end
            ADDR_OSC_STABILIZE: begin
               st_next.rdata[2:0] = st_reg.osc_stabilize_select_reg;
            end
            ADDR_STATUS: begin
               st_next.rdata[0] = st_reg.cpu_halt;
               st_next.rdata[1] = (st_reg.state == ST_SETUP)
                  || (st_reg.state == ST_RESET_SETUP);
               st_next.rdata[2] = st_reg.pll_saved;
               st_next.rdata[3] = st_reg.wake_branch;
            end
            default: begin
            end
         endcase
      end


      case (st_reg.state)
         ST_RESET_SETUP: begin
            // reset release waits the stabilise reset value before running
            if (st_reg.setup_cnt == '0) begin
               st_next.state = ST_RUN;
               st_next.clk_en = clocks_all_on();
               st_next.cpu_halt = 1'b0;
               st_next.pll_run = pll_run_sw;
            end else begin
               st_next.setup_cnt = st_reg.setup_cnt - SETUP_CNT_W'(1);
            end
         end

         ST_RUN: begin
            st_next.pll_run = pll_run_sw;
            if (entry_write) begin
               st_next.state = ST_ENTRY;
               st_next.pll_saved = pll_run_sw;
            end
         end

         ST_ENTRY: begin
            // one settling cycle while the cpu drains its trailing nops
            st_next.state = ST_IDLE;
            st_next.clk_en = idle_clk;
            st_next.pll_run = 1'b0;
            st_next.cpu_halt = 1'b1;
            st_next.ram_hold = 1'b1;
         end

         ST_IDLE: begin
            st_next.clk_en = idle_clk;
            // a request pending at entry is seen on the first idle cycle
            if (any_wake) begin
               st_next.state = ST_SETUP;
               st_next.setup_cnt = setup_cycles(st_reg.osc_stabilize_select_reg);
               st_next.pll_run = st_reg.pll_saved;
               st_next.clk_en.pll = st_reg.pll_saved;
               st_next.clk_en.flash = 1'b1;
               st_next.clk_en.intc = 1'b1;
               // nmi always branches, maskable branches only when taken
               st_next.wake_branch = nmi_wake
                  | (irq_enabled & higher_prio);
               st_next.wake_ack = nmi_wake | higher_prio;
            end
         end

         ST_SETUP: begin
            // execution stays halted until the stabilise timer overflows
            if (st_reg.setup_cnt == '0) begin
               st_next.state = ST_RUN;
               st_next.clk_en = clocks_all_on();
               st_next.cpu_halt = 1'b0;
               st_next.ram_hold = 1'b0;
               st_next.resume = 1'b1;
               st_next.resume_branch = st_reg.wake_branch;
               st_next.irq_ack_allow = st_reg.wake_ack;
            end else begin
               st_next.setup_cnt = st_reg.setup_cnt - SETUP_CNT_W'(1);
            end
         end
         default: begin
            st_next.state = ST_RUN;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         // pin reset in any state restarts through the full reset setup
         st_reg.nmi_meta <= 1'b0;
         st_reg.nmi_sync <= 1'b0;
         st_reg.ext_meta <= '0;
         st_reg.ext_sync <= '0;

         st_reg.power_save_mode_reg <= POWER_SAVE_MODE_RESET;
         st_reg.nonmaskable_src0_mask <= 1'b0;
         st_reg.nonmaskable_src1_mask <= 1'b0;
         st_reg.maskable_irq_mask <= 1'b0;
         st_reg.osc_stabilize_select_reg <= OSC_STABILIZE_RESET;

         st_reg.state <= ST_RESET_SETUP;
         st_reg.setup_cnt <= SETUP_CNT_W'(1) << (OSC_SHIFT_BASE + 6);

         st_reg.pll_saved <= 1'b0;
         st_reg.wake_branch <= 1'b0;
         st_reg.wake_ack <= 1'b0;
         st_reg.rdata <= '0;

         st_reg.clk_en <= '0;
         st_reg.pll_run <= 1'b0;
         st_reg.ram_hold <= 1'b0;
         st_reg.cpu_halt <= 1'b1;
         st_reg.resume <= 1'b0;
         st_reg.resume_branch <= 1'b0;
         st_reg.irq_ack_allow <= 1'b0;
         st_reg.sys_reset_req <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   always_comb begin
      reg_rdata = st_reg.rdata;

      clk_en = st_reg.clk_en;
      // main oscillator never stops here, only the stop mode may cut it
      osc_run = 1'b1;

      pll_run = st_reg.pll_run;
      ram_hold = st_reg.ram_hold;
      cpu_halt = st_reg.cpu_halt;
      sys_reset_req = st_reg.sys_reset_req;
      resume = st_reg.resume;
      resume_branch = st_reg.resume_branch;
      irq_ack_allow = st_reg.irq_ack_allow;
   end

endmodule : isc_standby_ctrl

// *** verification/deep_idle_mode_standby_control_tb_top.sv ***
// bench for the deep idle standby controller
// assumes isc_irq_partner and the bound checker
`timescale 1ns/100ps
module deep_idle_mode_standby_control_tb_top;
   import isc_pkg::*;
   // ---------------------------------------------
   // signals and helpers
   // ---------------------------------------------
   typedef struct packed {
      logic [2:0] src; logic [4:0] ctl; logic ie; logic svc;
      logic [2:0] rp; logic [2:0] sp; logic [1:0] care; logic [1:0] exp;
   } isc_case_type;
   logic ref_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, nmi_pin = 0, watchdog_irq = 0;
   logic in_service = 0, irq_enabled = 0, watchdog_reset = 0, clock_monitor_reset = 0;
   logic subclock_present = 0, pll_run_sw = 0, raise = 0, pending, rd_seen = 0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, seed = 32'h3731;
   logic [7:0] external_irq_pins = 8'h0, external_irq_mask = 8'hFE, periph_idle_capable = 8'h1;
   logic [2:0] request_prio = 3'h0, service_prio = 3'h0;
   logic osc_run, pll_run, ram_hold, cpu_halt, sys_reset_req, resume, resume_branch;
   logic irq_ack_allow;
   logic [5:0] note;
   isc_clk_sel_type clk_sel = '0;
   isc_clk_en_type clk_en;
   int checks = 0, mismatches = 0;
   logic [31:0] rd_q[$];
   logic [5:0] res_q[$];
   isc_case_type cases [6] = '{'{0, 5'h02, 0, 0, 0, 0, 2'h3, 2'h3}, '{2, 5'h02, 1, 0, 0, 0, 2'h3, 2'h3},
      '{2, 5'h02, 0, 0, 0, 0, 2'h2, 2'h0}, '{3, 5'h02, 1, 1, 5, 2, 2'h3, 2'h0},
      '{4, 5'h02, 1, 1, 1, 3, 2'h3, 2'h3}, '{5, 5'h16, 1, 0, 0, 0, 2'h3, 2'h3}};
   always #4 ref_clk = ~ref_clk;
   isc_standby_ctrl #(.OSC_SHIFT_BASE(0)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .nmi_pin(nmi_pin), .watchdog_irq(watchdog_irq),
      .external_irq_pins(external_irq_pins), .external_irq_mask(external_irq_mask),
      .periph_irq({7'h0, pending}), .periph_irq_mask(8'h0),
      .periph_idle_capable(periph_idle_capable), .request_prio(request_prio),
      .service_prio(service_prio), .in_service(in_service), .irq_enabled(irq_enabled),
      .watchdog_reset(watchdog_reset), .clock_monitor_reset(clock_monitor_reset),
      .subclock_present(subclock_present), .pll_run_sw(pll_run_sw), .clk_sel(clk_sel),
      .clk_en(clk_en), .osc_run(osc_run), .pll_run(pll_run), .ram_hold(ram_hold),
      .cpu_halt(cpu_halt), .sys_reset_req(sys_reset_req), .resume(resume),
      .resume_branch(resume_branch), .irq_ack_allow(irq_ack_allow));
   isc_irq_partner u_partner (.ref_clk(ref_clk), .reset_n(reset_n), .raise(raise),
      .ack(irq_ack_allow), .pending(pending));
   function automatic logic [31:0] xorshift();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xorshift
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict
   // the gap cycle keeps a strobe from being assigned twice in one step
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      rd_q.push_back(exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
   endtask : rd
   // values read right after an edge are those that stood before it
   task automatic wait_for(input logic want_resume, output int n);
      n = 0;
      do begin
         @(posedge ref_clk);
         raise <= 1'b0;
         n++;
      end while (n < 300 && (want_resume ? resume !== 1'b1 : cpu_halt !== 1'b0));
      check(32'(n < 300), 32'h1);
   endtask : wait_for
   task automatic reset_dut();
      int n;
      reset_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      reset_n <= 1'b1;
      wait_for(1'b0, n);
      check(32'(n >= 64), 32'h1);
   endtask : reset_dut
   task automatic run_case(input isc_case_type c);
      int n;
      logic [31:0] r;
      logic [2:0] t;
      r = xorshift();
      t = {(r[5:4] == ITMR_SEL_INT_OSC_DIV8) || (r[5:4] == ITMR_SEL_SUBCLOCK && r[6]),
         (r[3:2] == WTMR_SEL_MAIN_DIV) || r[6],
         (r[1:0] == WDOG_SEL_INT_OSC) || (r[1:0] == WDOG_SEL_SUBCLOCK && r[6])};
      clk_sel <= r[5:0];
      subclock_present <= r[6];
      pll_run_sw <= r[7];
      periph_idle_capable <= r[23:16] | 8'h1;
      external_irq_pins <= {r[15:9], 1'b0};
      irq_enabled <= c.ie;
      in_service <= c.svc;
      request_prio <= c.rp;
      service_prio <= c.sp;
      res_q.push_back({1'b1, c.care, r[7], c.exp});
      @(posedge ref_clk);
      wr(ADDR_STANDBY_CONTROL, {27'h0, c.ctl});
      if (c.src != 3'h4) begin
         repeat (5) @(posedge ref_clk);
         check(32'(cpu_halt & ram_hold & ~pll_run), 32'h1);
         check(32'({clk_en.cpu, clk_en.pll, clk_en.flash, clk_en.periph, clk_en.intc,
            clk_en.ext_clk_periph}), 32'h1);
         check(32'({clk_en.interval_timer, clk_en.watch_timer, clk_en.watchdog}),
            32'(t));
      end
      case (c.src)
         3'h0: nmi_pin <= 1'b1;
         3'h1: watchdog_irq <= 1'b1;
         3'h2: external_irq_pins[0] <= 1'b1;
         3'h3: raise <= 1'b1;
         3'h5: begin
            nmi_pin <= 1'b1;
            external_irq_pins[0] <= 1'b1;
            repeat (20) @(posedge ref_clk);
            check(32'(cpu_halt), 32'h1);
            watchdog_irq <= 1'b1;
         end
         default: ;
      endcase
      wait_for(1'b1, n);
      if (c.src != 3'h4) check(32'(n >= 4), 32'h1);
      nmi_pin <= 1'b0;
      watchdog_irq <= 1'b0;
      external_irq_pins <= 8'h0;
      repeat (3) @(posedge ref_clk);
      check(32'(pending), 32'(c.src == 3'h3));
   endtask : run_case
   // ---------------------------------------------
   // result monitor and main sequence
   // ---------------------------------------------
   always @(posedge ref_clk) begin
      rd_seen <= reg_rd;
      if (rd_seen) check(reg_rdata, rd_q.pop_front());
      if (resume === 1'b1) begin
         note = res_q.pop_front();
         check(32'({pll_run, resume_branch, irq_ack_allow} & note[5:3]),
            32'(note[2:0] & note[5:3]));
      end
   end
   initial begin
      #(8 * 40000);
      mismatches++;
      give_verdict();
   end
   initial begin
      reset_dut();
      rd(ADDR_POWER_SAVE_MODE, 32'h0);
      rd(ADDR_OSC_STABILIZE, 32'(OSC_STABILIZE_RESET));
      rd(ADDR_STANDBY_CONTROL, 32'h0);
      rd(ADDR_STATUS, 32'h0);
      wr(4'h2, 32'hFFFFFFFF);
      rd(4'h2, 32'h0);
      wr(ADDR_STANDBY_CONTROL, 32'h2);
      repeat (3) @(posedge ref_clk);
      check(32'(cpu_halt), 32'h0);
      wr(ADDR_OSC_STABILIZE, 32'h2);
      rd(ADDR_OSC_STABILIZE, 32'h2);
      wr(ADDR_POWER_SAVE_MODE, 32'(MODE_DEEP_IDLE));
      rd(ADDR_POWER_SAVE_MODE, 32'(MODE_DEEP_IDLE));
      for (int i = 0; i < 6; i++) begin
         run_case(cases[i]);
      end
      // a reset in deep idle must look like a cold start
      wr(ADDR_STANDBY_CONTROL, 32'h2);
      repeat (5) @(posedge ref_clk);
      watchdog_reset <= 1'b1;
      @(posedge ref_clk);
      watchdog_reset <= 1'b0;
      clock_monitor_reset <= 1'b1;
      @(posedge ref_clk);
      clock_monitor_reset <= 1'b0;
      reset_dut();
      rd(ADDR_POWER_SAVE_MODE, 32'h0);
      rd(ADDR_OSC_STABILIZE, 32'(OSC_STABILIZE_RESET));
      repeat (3) @(posedge ref_clk);
      give_verdict();
   end
endmodule : deep_idle_mode_standby_control_tb_top

// *** verification/isc_irq_partner.sv ***
// interrupt controller model holding one peripheral request
// assumes the acknowledge pulse comes with resume
`timescale 1ns/100ps
module isc_irq_partner (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic raise,
   input wire logic ack,
   output logic pending
);
   // ---------------------------------------------
   // pending request
   // ---------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pending <= 1'b0;
      end else if (raise) begin
         pending <= 1'b1;
      end else if (ack) begin
         pending <= 1'b0;
      end
   end
endmodule : isc_irq_partner

// *** verification/isc_sc_asserts.sv ***
// port checker for the deep idle standby controller
// assumes a bind onto isc_standby_ctrl, one clock domain
`timescale 1ns/100ps
module isc_sc_asserts
   import isc_pkg::*;
#(
   parameter int OSC_SHIFT_BASE = 0
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic watchdog_reset,
   input wire logic clock_monitor_reset,
   input wire isc_pkg::isc_clk_en_type clk_en,
   input wire logic osc_run,
   input wire logic ram_hold,
   input wire logic cpu_halt,
   input wire logic sys_reset_req,
   input wire logic resume,
   input wire logic irq_ack_allow
);
   // ---------------------------------------------
   // helper state
   // ---------------------------------------------
   localparam int RESET_WAIT = 1 << (OSC_SHIFT_BASE + 6);
   int boot_cnt;
   logic [1:0] mode_q;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // shadow of the mode field, since the checker cannot see it
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         boot_cnt <= 0;
         mode_q <= 2'h0;
      end else begin
         if (boot_cnt < RESET_WAIT) begin
            boot_cnt <= boot_cnt + 1;
         end
         if (reg_wr && reg_addr == ADDR_POWER_SAVE_MODE) begin
            mode_q <= reg_wdata[1:0];
         end
      end
   end
   a_osc_runs: assert property (osc_run) else $error("oscillator stopped");
   a_idle_gated: assert property (ram_hold && !clk_en.flash |-> !clk_en.cpu && !clk_en.pll
      && !clk_en.periph && !clk_en.dma && !clk_en.rom_corr && !clk_en.gen_timer)
      else $error("clock not gated in deep idle");
   a_ram_halted: assert property (ram_hold |-> cpu_halt && !clk_en.cpu)
      else $error("cpu running while ram held");
   a_entry_taken: assert property (reg_wr && reg_addr == ADDR_STANDBY_CONTROL
      && reg_wdata[1] && mode_q == MODE_DEEP_IDLE && !cpu_halt |-> ##[1:3] cpu_halt && ram_hold)
      else $error("entry write not taken");
   a_entry_refused: assert property (reg_wr && reg_addr == ADDR_STANDBY_CONTROL
      && mode_q != MODE_DEEP_IDLE && !ram_hold |=> !ram_hold) else $error("entry in wrong mode");
   a_boot_wait: assert property (boot_cnt < RESET_WAIT |-> cpu_halt && !resume)
      else $error("reset setup too short");
   a_resume_setup: assert property (resume |-> $past(ram_hold) && clk_en.cpu ##1 !resume)
      else $error("resume without setup");
   a_ack_resume: assert property (irq_ack_allow |-> resume)
      else $error("acknowledge outside resume");
   a_reset_request: assert property (watchdog_reset || clock_monitor_reset |=> sys_reset_req)
      else $error("reset source ignored");
endmodule : isc_sc_asserts

bind isc_standby_ctrl isc_sc_asserts #(.OSC_SHIFT_BASE(OSC_SHIFT_BASE)) u_asserts (
   .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .watchdog_reset(watchdog_reset), .clock_monitor_reset(clock_monitor_reset),
   .clk_en(clk_en), .osc_run(osc_run), .ram_hold(ram_hold), .cpu_halt(cpu_halt),
   .sys_reset_req(sys_reset_req), .resume(resume), .irq_ack_allow(irq_ack_allow));
